// ==== common/asr_pkg.sv ====
// Package of constants shared by the acceleration readout ends
package asr_pkg;
    localparam int          SAMPLE_W      = 14;
    localparam int          REG_W         = 8;
    localparam int          ADDR_W        = 8;
    localparam int          NUM_CH        = 3;
    localparam int          LOW_BITS      = 6;
    localparam int          LOW_DATA_POS  = 2;
    localparam int          JUNK_POS      = 1;
    localparam int          FRESH_POS     = 0;
    localparam logic [7:0]  X_LOW_OFFSET  = 8'h02;
    localparam logic [7:0]  X_HIGH_OFFSET = 8'h03;
    localparam logic [7:0]  Y_LOW_OFFSET  = 8'h04;
    localparam logic [7:0]  Y_HIGH_OFFSET = 8'h05;
    localparam logic [7:0]  Z_LOW_OFFSET  = 8'h06;
    localparam logic [7:0]  Z_HIGH_OFFSET = 8'h07;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    localparam logic [13:0] SAMPLE_RESET  = 14'h0000;
    // Host-side software registers
    localparam logic [7:0]  H_CMD_OFFSET    = 8'h00;
    localparam logic [7:0]  H_STATUS_OFFSET = 8'h01;
    localparam logic [7:0]  H_X_OFFSET      = 8'h02;
    localparam logic [7:0]  H_Y_OFFSET      = 8'h03;
    localparam logic [7:0]  H_Z_OFFSET      = 8'h04;
    localparam logic [7:0]  H_IRQ_OFFSET    = 8'h05;
    localparam logic [7:0]  H_MASK_OFFSET   = 8'h06;
    localparam int          CMD_GO_POS      = 0;
    localparam int          CMD_BYPASS_POS  = 1;
    localparam int          STAT_BUSY_POS   = 0;
    localparam int          IRQ_DONE_POS    = 0;
    localparam int          IRQ_FRESH_POS   = 1;
    localparam logic [3:0]  BURST_LEN       = 4'h6;
endpackage

// ==== common/asr_if.sv ====
// Register port between the readout device and its host
`timescale 1ns/1ps
interface asr_if;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] rdata;
    logic       bypass;
    modport dev  (input rd, input addr, input bypass, output rdata);
    modport host (output rd, output addr, output bypass, input rdata);
endinterface

// ==== hw/asr_device.sv ====
// Device end: acceleration sample registers with low/high coherency lock
`timescale 1ns/1ps
// Operation
// - Low read with bypass clear freezes high half until read
// - Host reads low before high, bypass clear
// - Burst low-to-high read gives coherent sample
// - Host avoids reads during power-up, deep suspend
// - Low sample bits 5..0 in bits 7..2
// - Bit 1 of low half is don't-care
// - Bit 0 flags update since last readout
// - High half carries sample bits 13..6
// - Sample is signed two's complement
// - X,Y,Z pairs at 0x02, 0x04, 0x06
module asr_device #(
    parameter int CH = asr_pkg::NUM_CH
) (
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 clk_en,
    asr_if.dev                        bus,
    input  wire logic [CH*14-1:0]     sample,
    input  wire logic [CH-1:0]        sample_valid,
    output logic                      ready
);
    // The offset table below only knows three channels
    if (CH != asr_pkg::NUM_CH) begin : g_bad_ch
        $error("asr_device serves exactly three channels");
    end

    ////////////////////////////////////////////////////////////////////////
    logic [CH*14-1:0] cur;
    logic [CH*8-1:0]  high_hold;
    logic [CH-1:0]    locked;
    logic [CH-1:0]    fresh;
    logic [7:0]       rdata_q;
    logic [7:0]       low_off [CH];
    logic [7:0]       high_off [CH];
    logic [7:0]       next_rdata;

    assign low_off[0]  = asr_pkg::X_LOW_OFFSET;
    assign low_off[1]  = asr_pkg::Y_LOW_OFFSET;
    assign low_off[2]  = asr_pkg::Z_LOW_OFFSET;
    assign high_off[0] = asr_pkg::X_HIGH_OFFSET;
    assign high_off[1] = asr_pkg::Y_HIGH_OFFSET;
    assign high_off[2] = asr_pkg::Z_HIGH_OFFSET;
    assign bus.rdata   = rdata_q;
    assign ready       = nrst;

    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_ch
            wire        rd_low  = bus.rd && (bus.addr == low_off[g]);
            wire        rd_high = bus.rd && (bus.addr == high_off[g]);
            wire [13:0] s       = cur[g*14 +: 14];

            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    cur[g*14 +: 14]      <= asr_pkg::SAMPLE_RESET;
                    high_hold[g*8 +: 8]  <= asr_pkg::REG_RESET;
                    locked[g]            <= 1'b0;
                    fresh[g]             <= 1'b0;
                end else if (clk_en) begin
                    if (sample_valid[g]) begin
                        cur[g*14 +: 14] <= sample[g*14 +: 14];
                    end
                    // New sample wins over the clear of a same-cycle read
                    if (sample_valid[g]) begin
                        fresh[g] <= 1'b1;
                    end else if (rd_low || rd_high) begin
                        fresh[g] <= 1'b0;
                    end
                    if (rd_low && !bus.bypass) begin
                        locked[g]           <= 1'b1;
                        high_hold[g*8 +: 8] <= s[13:6];
                    end else if (rd_high) begin
                        locked[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_rdata = asr_pkg::REG_RESET;
        for (int i = 0; i < CH; i++) begin
            if (bus.addr == low_off[i]) begin
                next_rdata = {cur[i*14 +: 6], 1'b0, fresh[i]};
            end
            if (bus.addr == high_off[i]) begin
                // Live high half unless frozen by a prior low read
                next_rdata = locked[i] ? high_hold[i*8 +: 8] : cur[i*14+6 +: 8];
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= asr_pkg::REG_RESET;
        end else if (clk_en && bus.rd) begin
            rdata_q <= next_rdata;
        end
    end
endmodule

// ==== hw/asr_host.sv ====
// Host end: burst reader of the three acceleration channels
`timescale 1ns/1ps
module asr_host (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        clk_en,
    asr_if.host              bus,
    input  wire logic [7:0]  sw_addr,
    input  wire logic [15:0] sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic      [15:0] sw_rdata,
    output logic             irq
);
    typedef enum logic [1:0] {
        ASRH_IDLE = 2'b00,
        ASRH_READ = 2'b01,
        ASRH_LAST = 2'b10
    } asrh_state_t;

    ////////////////////////////////////////////////////////////////////////
    asrh_state_t state;
    logic [3:0]  idx;
    logic [3:0]  cap_idx;
    logic        cap_v;
    logic        bypass_q;
    logic [7:0]  lows [3];
    logic [13:0] samp [3];
    logic [2:0]  fresh_any;
    logic [1:0]  irq_st;
    logic [1:0]  irq_mask;
    logic [15:0] rdata_q;
    logic [15:0] next_rdata;

    wire go     = sw_wr && (sw_addr == asr_pkg::H_CMD_OFFSET) && sw_wdata[asr_pkg::CMD_GO_POS];
    wire start  = go && (state == ASRH_IDLE);
    wire done   = cap_v && (cap_idx == asr_pkg::BURST_LEN - 4'h1);
    wire irq_wr = sw_wr && (sw_addr == asr_pkg::H_IRQ_OFFSET);
    // Low byte fresh bit of each channel, seen at the low read
    wire fresh_ev = cap_v && !cap_idx[0] && bus.rdata[asr_pkg::FRESH_POS];

    // Burst from X low upward: each low read precedes its high read
    // Reads only after a software go, never while held in reset
    assign bus.rd     = (state == ASRH_READ);
    assign bus.addr   = asr_pkg::X_LOW_OFFSET + {4'h0, idx};
    assign bus.bypass = bypass_q;
    assign irq        = |(irq_st & irq_mask);
    assign sw_rdata   = rdata_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state    <= ASRH_IDLE;
            idx      <= 4'h0;
            cap_v    <= 1'b0;
            cap_idx  <= 4'h0;
            bypass_q <= 1'b0;
        end else if (clk_en) begin
            cap_v   <= bus.rd;
            cap_idx <= idx;
            case (state)
                ASRH_IDLE: begin
                    if (start) begin
                        state    <= ASRH_READ;
                        idx      <= 4'h0;
                        bypass_q <= sw_wdata[asr_pkg::CMD_BYPASS_POS];
                    end
                end
                ASRH_READ: begin
                    if (idx == asr_pkg::BURST_LEN - 4'h1) begin
                        state <= ASRH_LAST;
                    end else begin
                        idx <= idx + 4'h1;
                    end
                end
                ASRH_LAST: state <= ASRH_IDLE;
                default:   state <= ASRH_IDLE;
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_cap
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    lows[g]      <= 8'h00;
                    samp[g]      <= 14'h0000;
                    fresh_any[g] <= 1'b0;
                end else if (clk_en && cap_v && (cap_idx[3:1] == 3'(g))) begin
                    if (!cap_idx[0]) begin
                        lows[g]      <= bus.rdata;
                        fresh_any[g] <= bus.rdata[asr_pkg::FRESH_POS];
                    end else begin
                        // Bit 1 of the low byte is junk and dropped
                        samp[g] <= {bus.rdata, lows[g][7:2]};
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_st   <= 2'h0;
            irq_mask <= 2'h0;
        end else if (clk_en) begin
            for (int b = 0; b < 2; b++) begin
                if ((b == asr_pkg::IRQ_DONE_POS && done) || (b == asr_pkg::IRQ_FRESH_POS && fresh_ev)) begin
                    irq_st[b] <= 1'b1;
                end else if (irq_wr && sw_wdata[b]) begin
                    irq_st[b] <= 1'b0;
                end
            end
            if (sw_wr && (sw_addr == asr_pkg::H_MASK_OFFSET)) begin
                irq_mask <= sw_wdata[1:0];
            end
        end
    end

    always_comb begin
        next_rdata = 16'h0000;
        case (sw_addr)
            asr_pkg::H_CMD_OFFSET:    next_rdata = {14'h0000, bypass_q, 1'b0};
            asr_pkg::H_STATUS_OFFSET: next_rdata = {12'h000, fresh_any, state != ASRH_IDLE};
            asr_pkg::H_X_OFFSET:      next_rdata = {{2{samp[0][13]}}, samp[0]};
            asr_pkg::H_Y_OFFSET:      next_rdata = {{2{samp[1][13]}}, samp[1]};
            asr_pkg::H_Z_OFFSET:      next_rdata = {{2{samp[2][13]}}, samp[2]};
            asr_pkg::H_IRQ_OFFSET:    next_rdata = {14'h0000, irq_st};
            asr_pkg::H_MASK_OFFSET:   next_rdata = {14'h0000, irq_mask};
            default:                  next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 16'h0000;
        end else if (clk_en && sw_rd) begin
            rdata_q <= next_rdata;
        end
    end
endmodule

// ==== verif/asr_properties.sv ====
// Concurrent checks on the register port between host and device ends
`timescale 1ns/1ps
module asr_properties (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       rd,
    input wire logic [7:0] addr,
    input wire logic [7:0] rdata,
    input wire logic       bypass
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////
    sequence s_tail;
        rd && addr == 8'h03 ##1 rd && addr == 8'h04 ##1 rd && addr == 8'h05
        ##1 rd && addr == 8'h06 ##1 rd && addr == 8'h07 ##1 !rd;
    endsequence
    sequence s_open;
        $rose(rd);
    endsequence
    a_burst_start: assert property (s_open |-> addr == 8'h02)
        else $error("burst opens away from the X low register");
    a_burst_walk: assert property (s_open |=> s_tail)
        else $error("burst address walk broken");
    a_burst_len: assert property (s_open |-> rd [*6] ##1 !rd)
        else $error("burst is not six reads long");
    a_low_then_high: assert property (rd && !addr[0] |=> rd && addr == $past(addr) + 8'h01)
        else $error("low read not followed by its high read");
    a_addr_mapped: assert property (rd |-> addr inside {[8'h02:8'h07]})
        else $error("read outside the sample registers");
    a_junk_bit: assert property (rd && !addr[0] |=> rdata[1] == 1'b0)
        else $error("low register bit 1 not driven low");
    // Read data must not drift between reads, or a slow host sees torn values
    a_rdata_stands: assert property (!rd |=> $stable(rdata))
        else $error("read data changed without a read");
    a_bypass_steady: assert property (rd && $past(rd) |-> $stable(bypass))
        else $error("bypass moved inside a burst");
endmodule

// ==== verif/test_accel_sample_readout_regs.sv ====
// Testbench joining the device end and the host end of the readout port
`timescale 1ns/1ps
module test_accel_sample_readout_regs;
    localparam logic [41:0] PA = {14'h3F3C, 14'h1FEA, 14'h2015};
    localparam logic [41:0] PB = {14'h0155, 14'h2AAA, 14'h1E41};
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [41:0] sample = 42'h0;
    logic [2:0]  sample_valid = 3'h0;
    logic [7:0]  sw_addr = 8'h00;
    logic [15:0] sw_wdata = 16'h0000;
    logic        sw_wr = 1'b0;
    logic        sw_rd = 1'b0;
    logic [15:0] sw_rdata;
    logic        irq;
    logic        ready;
    int          n_mismatch = 0;
    int          total_checks = 0;
    always #4 clk = ~clk;
    asr_if bus ();
    asr_device i_asr_device (.clk(clk), .nrst(nrst), .clk_en(1'b1), .bus(bus), .sample(sample),
        .sample_valid(sample_valid), .ready(ready));
    asr_host i_asr_host (.clk(clk), .nrst(nrst), .clk_en(1'b1), .bus(bus), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq));
    asr_properties i_asr_properties (.clk(clk), .nrst(nrst), .rd(bus.rd), .addr(bus.addr),
        .rdata(bus.rdata), .bypass(bus.bypass));
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic sw_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
        #1;
    endtask
    task automatic sw_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1;
        d = sw_rdata;
    endtask
    task automatic load(input logic [41:0] s);
        @(posedge clk);
        sample <= s;
        sample_valid <= 3'h7;
        @(posedge clk);
        sample_valid <= 3'h0;
    endtask
    // Polls busy with a bound so a stuck burst ends the run
    task automatic wait_done();
        logic [15:0] st;
        for (int i = 0; i < 20; i++) begin
            sw_read(asr_pkg::H_STATUS_OFFSET, st);
            if (st[0] === 1'b0) return;
        end
        n_mismatch++;
        summarize();
    endtask
    task automatic check_axes(input logic [41:0] s);
        logic [15:0] v;
        for (int g = 0; g < 3; g++) begin
            sw_read(asr_pkg::H_X_OFFSET + g[7:0], v);
            check16("axis", {{2{s[g*14+13]}}, s[g*14+:14]}, v);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic s_coherent();
        logic [15:0] v;
        load(PA);
        sw_write(asr_pkg::H_MASK_OFFSET, 16'h0000);
        sw_write(asr_pkg::H_CMD_OFFSET, 16'h0001);
        wait_done();
        check_axes(PA);
        sw_read(asr_pkg::H_IRQ_OFFSET, v);
        check16("irq_status", 16'h0003, v);
        check_bit("irq", 1'b0, irq);
        sw_write(asr_pkg::H_MASK_OFFSET, 16'h0002);
        check_bit("irq", 1'b1, irq);
        sw_write(asr_pkg::H_IRQ_OFFSET, 16'h0003);
        check_bit("irq", 1'b0, irq);
        // No new sample since the last burst, so no low read may flag fresh
        sw_write(asr_pkg::H_CMD_OFFSET, 16'h0001);
        wait_done();
        sw_read(asr_pkg::H_IRQ_OFFSET, v);
        check16("irq_status", 16'h0001, v);
        check_bit("irq", 1'b0, irq);
        sw_write(asr_pkg::H_IRQ_OFFSET, 16'h0001);
    endtask
    // New sample lands on the X low read edge; Y and Z are read later
    task automatic s_lock(input logic bp);
        logic [41:0] e;
        load(PA);
        sw_write(asr_pkg::H_CMD_OFFSET, {14'h0000, bp, 1'b1});
        sample <= PB;
        sample_valid <= 3'h7;
        @(posedge clk);
        sample_valid <= 3'h0;
        wait_done();
        e = {PB[41:14], bp ? PB[13:6] : PA[13:6], PA[5:0]};
        check_axes(e);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        #1;
        check_bit("ready", 1'b1, ready);
        s_coherent();
        s_lock(1'b0);
        s_lock(1'b1);
        summarize();
    end
endmodule
